// ===== logic/pio_host.v
// host side controller for pio register cycles with ready extension
`timescale 1ns/1ps
`include "pio_regs.vh"
module pio_host (
    input  wire        i_clock,
    input  wire        i_rstn,
    // user side
    input  wire        i_req,
    input  wire        i_write,
    input  wire        i_cs1,
    input  wire [2:0]  i_addr,
    input  wire        i_byte,
    input  wire [15:0] i_wdata,
    input  wire [2:0]  i_mode,
    output wire        o_ready,
    output reg         o_done,
    output reg         o_timeout,
    output reg         o_wide,
    output reg  [15:0] o_rdata,
    // device pins
    output reg         o_cs0_n,
    output reg         o_cs1_n,
    output reg  [2:0]  o_da,
    output reg         o_iord_n,
    output reg         o_iowr_n,
    input  wire [15:0] i_dd,
    output reg  [15:0] o_dd,
    output reg         o_dd_oe_n,
    input  wire        i_iordy,
    input  wire        i_iocs16_n
);
    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [3:0] ST_IDLE    = 4'h1;
    localparam [3:0] ST_SETUP   = 4'h2;
    localparam [3:0] ST_STROBE  = 4'h4;
    localparam [3:0] ST_RECOVER = 4'h8;

    localparam [7:0] SYNC_CYC = `PIO_SYNC_STAGES;

    // ------------------------------------------------------------------
    // time conversion
    // ------------------------------------------------------------------
    function [7:0] cyc_up;
        input integer ns;
        integer c;
        begin
            c = (ns * 1000 + `PIO_CLK_PERIOD_PS - 1) / `PIO_CLK_PERIOD_PS;
            if (c < 1)
                c = 1;
            cyc_up = c[7:0];
        end
    endfunction

    // kind: 0 cycle, 1 setup, 2 word strobe, 3 byte strobe, 4 recovery, 5 hold
    function integer mode_ns;
        input [2:0] mode;
        input [2:0] kind;
        begin
            mode_ns = 0;
            case (kind)
                3'h0: case (mode)
                    3'h0: mode_ns = `PIO_T0_M0;
                    3'h1: mode_ns = `PIO_T0_M1;
                    3'h2: mode_ns = `PIO_T0_M2;
                    3'h3: mode_ns = `PIO_T0_M3;
                    3'h4: mode_ns = `PIO_T0_M4;
                    3'h5: mode_ns = `PIO_T0_M5;
                    default: mode_ns = `PIO_T0_M6;
                endcase
                3'h1: case (mode)
                    3'h0: mode_ns = `PIO_T1_M0;
                    3'h1: mode_ns = `PIO_T1_M1;
                    3'h2: mode_ns = `PIO_T1_M2;
                    3'h3: mode_ns = `PIO_T1_M3;
                    3'h4: mode_ns = `PIO_T1_M4;
                    3'h5: mode_ns = `PIO_T1_M5;
                    default: mode_ns = `PIO_T1_M6;
                endcase
                3'h2: case (mode)
                    3'h0: mode_ns = `PIO_T2W_M0;
                    3'h1: mode_ns = `PIO_T2W_M1;
                    3'h2: mode_ns = `PIO_T2W_M2;
                    3'h3: mode_ns = `PIO_T2W_M3;
                    3'h4: mode_ns = `PIO_T2W_M4;
                    3'h5: mode_ns = `PIO_T2W_M5;
                    default: mode_ns = `PIO_T2W_M6;
                endcase
                3'h3: case (mode)
                    3'h0: mode_ns = `PIO_T2B_M0;
                    3'h1: mode_ns = `PIO_T2B_M1;
                    3'h2: mode_ns = `PIO_T2B_M2;
                    3'h3: mode_ns = `PIO_T2B_M3;
                    3'h4: mode_ns = `PIO_T2B_M4;
                    3'h5: mode_ns = `PIO_T2B_M5;
                    default: mode_ns = `PIO_T2B_M6;
                endcase
                3'h4: case (mode)
                    3'h0: mode_ns = `PIO_T2I_M0;
                    3'h1: mode_ns = `PIO_T2I_M1;
                    3'h2: mode_ns = `PIO_T2I_M2;
                    3'h3: mode_ns = `PIO_T2I_M3;
                    3'h4: mode_ns = `PIO_T2I_M4;
                    3'h5: mode_ns = `PIO_T2I_M5;
                    default: mode_ns = `PIO_T2I_M6;
                endcase
                default: case (mode)
                    3'h0: mode_ns = `PIO_T4_M0;
                    3'h1: mode_ns = `PIO_T4_M1;
                    3'h2: mode_ns = `PIO_T4_M2;
                    3'h3: mode_ns = `PIO_T4_M3;
                    3'h4: mode_ns = `PIO_T4_M4;
                    3'h5: mode_ns = `PIO_T4_M5;
                    default: mode_ns = `PIO_T4_M6;
                endcase
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    wire [17:0] pins_sync;

    pio_sync #(
        .WIDTH       (18),
        .RESET_VALUE (18'h30000)
    ) u_sync (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_async ({i_iocs16_n, i_iordy, i_dd}),
        .o_sync  (pins_sync)
    );

    wire        iordy_s   = pins_sync[16];
    wire        iocs16_s  = ~pins_sync[17];
    wire [15:0] dd_s      = pins_sync[15:0];

    // ------------------------------------------------------------------
    // cycle state
    // ------------------------------------------------------------------
    reg [3:0] state;
    reg [7:0] cnt;
    reg [7:0] setup_cyc;
    reg [7:0] strobe_cyc;
    reg [7:0] rec_cyc;
    reg [2:0] mode;
    reg       is_write;
    reg       is_byte;
    reg       waiting;
    reg       seen16;

    localparam [7:0] SAMPLE_AT = cyc_up(`PIO_READY_SAMPLE_NS) + SYNC_CYC;
    localparam [7:0] WAIT_MAX  = cyc_up(`PIO_READY_LOW_MAX_NS) - 8'h01;

    assign o_ready = (state == ST_IDLE);

    wire wait_ok  = (mode <= `PIO_LAST_WAIT_MODE);
    wire honour16 = (mode <= `PIO_LAST_IOCS16_MODE);
    wire strobe_done = (cnt >= strobe_cyc - 8'h01);
    wire start_wait = !waiting && cnt == SAMPLE_AT && wait_ok && !iordy_s;
    wire wait_over  = (iordy_s && strobe_done) || cnt >= WAIT_MAX + SAMPLE_AT;
    wire strobe_end = waiting ? wait_over : strobe_done && !start_wait;

    // word strobe minimum or the byte one (longer in modes 0 to 2), plus sync latency so
    // read data seen through the synchroniser is still strobe-valid
    wire [7:0] t2_sel = is_byte ? cyc_up(mode_ns(mode, 3'h3))
                                : cyc_up(mode_ns(mode, 3'h2));

    // recovery: recovery minimum, rest of cycle time, and write hold
    function [7:0] recovery;
        input [2:0] m;
        input [7:0] used;
        reg [7:0] r;
        reg [7:0] t0c;
        reg [7:0] t2ic;
        reg [7:0] t4c;
        begin
            t0c  = cyc_up(mode_ns(m, 3'h0));
            t2ic = cyc_up(mode_ns(m, 3'h4));
            t4c  = cyc_up(mode_ns(m, 3'h5));
            r = (t0c > used) ? t0c - used : 8'h01;
            if (t2ic > r)
                r = t2ic;
            if (t4c > r)
                r = t4c;
            recovery = r;
        end
    endfunction

    always @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state      <= ST_IDLE;
            cnt        <= 8'h00;
            setup_cyc  <= 8'h01;
            strobe_cyc <= 8'h01;
            rec_cyc    <= 8'h01;
            mode       <= 3'h0;
            is_write   <= 1'b0;
            is_byte    <= 1'b0;
            waiting    <= 1'b0;
            seen16     <= 1'b0;
            o_done     <= 1'b0;
            o_timeout  <= 1'b0;
            o_wide     <= 1'b0;
            o_rdata    <= 16'h0000;
            o_cs0_n    <= 1'b1;
            o_cs1_n    <= 1'b1;
            o_da       <= 3'h0;
            o_iord_n   <= 1'b1;
            o_iowr_n   <= 1'b1;
            o_dd       <= 16'h0000;
            o_dd_oe_n  <= 1'b1;
        end
        else
        begin
            o_done    <= 1'b0;
            o_timeout <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (i_req)
                    begin
                        state     <= ST_SETUP;
                        cnt       <= 8'h00;
                        mode      <= i_mode;
                        is_write  <= i_write;
                        is_byte   <= i_byte;
                        seen16    <= 1'b0;
                        setup_cyc <= cyc_up(mode_ns(i_mode, 3'h1));
                        o_cs0_n   <= i_cs1;
                        o_cs1_n   <= ~i_cs1;
                        o_da      <= i_addr;
                        o_dd      <= i_byte ? {8'h00, i_wdata[7:0]}
                                            : i_wdata;
                        o_dd_oe_n <= ~i_write;
                    end
                end
                ST_SETUP:
                begin
                    if (iocs16_s)
                        seen16 <= 1'b1;
                    cnt <= cnt + 8'h01;
                    if (cnt >= setup_cyc - 8'h01)
                    begin
                        state      <= ST_STROBE;
                        cnt        <= 8'h00;
                        waiting    <= 1'b0;
                        // never end before the ready sample is taken
                        strobe_cyc <= (t2_sel + SYNC_CYC > SAMPLE_AT + 8'h01)
                                      ? t2_sel + SYNC_CYC
                                      : SAMPLE_AT + 8'h01;
                        o_iord_n   <= is_write;
                        o_iowr_n   <= ~is_write;
                    end
                end
                ST_STROBE:
                begin
                    if (iocs16_s)
                        seen16 <= 1'b1;
                    cnt <= cnt + 8'h01;
                    if (start_wait)
                        waiting <= 1'b1;
                    if (strobe_end)
                    begin
                        state    <= ST_RECOVER;
                        cnt      <= 8'h00;
                        rec_cyc  <= recovery(mode, setup_cyc + cnt);
                        o_timeout <= waiting & ~iordy_s;
                        o_iord_n <= 1'b1;
                        o_iowr_n <= 1'b1;
                        o_done   <= 1'b1;
                        o_wide   <= ~is_byte & (~honour16 | seen16);
                        if (!is_write)
                            o_rdata <= (is_byte | (honour16 & ~seen16))
                                       ? {8'h00, dd_s[7:0]} : dd_s;
                    end
                end
                ST_RECOVER:
                begin
                    cnt <= cnt + 8'h01;
                    if (cnt >= rec_cyc - 8'h01)
                    begin
                        state     <= ST_IDLE;
                        o_cs0_n   <= 1'b1;
                        o_cs1_n   <= 1'b1;
                        o_dd_oe_n <= 1'b1;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
endmodule // pio_host

// ===== logic/pio_regs.vh
// timing figures and constants for the pio host cycle controller
// ----------------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------------
`ifndef PIO_REGS_VH
`define PIO_REGS_VH

`define PIO_CLK_PERIOD_PS      20000
`define PIO_SYNC_STAGES        2
`define PIO_READY_SAMPLE_NS    35
`define PIO_READY_LOW_MAX_NS   1250
`define PIO_READ_DATA_LEAD_NS  0
`define PIO_LAST_IOCS16_MODE   2
`define PIO_LAST_WAIT_MODE     4

// cycle time t0 per mode
`define PIO_T0_M0  600
`define PIO_T0_M1  383
`define PIO_T0_M2  240
`define PIO_T0_M3  180
`define PIO_T0_M4  120
`define PIO_T0_M5  100
`define PIO_T0_M6  80
// address setup t1 per mode
`define PIO_T1_M0  70
`define PIO_T1_M1  50
`define PIO_T1_M2  30
`define PIO_T1_M3  30
`define PIO_T1_M4  25
`define PIO_T1_M5  15
`define PIO_T1_M6  10
// strobe width, word access
`define PIO_T2W_M0 165
`define PIO_T2W_M1 125
`define PIO_T2W_M2 100
`define PIO_T2W_M3 80
`define PIO_T2W_M4 70
`define PIO_T2W_M5 65
`define PIO_T2W_M6 55
// strobe width, byte register access
`define PIO_T2B_M0 290
`define PIO_T2B_M1 290
`define PIO_T2B_M2 290
`define PIO_T2B_M3 80
`define PIO_T2B_M4 70
`define PIO_T2B_M5 65
`define PIO_T2B_M6 55
// strobe recovery time, zero where none is given
`define PIO_T2I_M0 0
`define PIO_T2I_M1 0
`define PIO_T2I_M2 0
`define PIO_T2I_M3 70
`define PIO_T2I_M4 25
`define PIO_T2I_M5 25
`define PIO_T2I_M6 20
// write data hold, also covers the address hold
`define PIO_T4_M0  30
`define PIO_T4_M1  20
`define PIO_T4_M2  15
`define PIO_T4_M3  10
`define PIO_T4_M4  10
`define PIO_T4_M5  5
`define PIO_T4_M6  5

`endif

// ===== logic/pio_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pio_sync #(
    parameter             WIDTH       = 1,
    // idle pin levels, so no wait or width indication shows out of reset
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input  wire             i_clock,
    input  wire             i_rstn,
    input  wire [WIDTH-1:0] i_async,
    output reg  [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] stage1;

    always @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            stage1 <= RESET_VALUE;
            o_sync <= RESET_VALUE;
        end
        else
        begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule // pio_sync

// ===== sim/pio_host_monitor.sv
// assertion checker bound to the pio host cycle controller
`timescale 1ns/1ps
module pio_host_monitor (
    input wire       i_clock,
    input wire       i_rstn,
    input wire       i_req,
    input wire       i_cs1,
    input wire [2:0] i_addr,
    input wire       i_byte,
    input wire [2:0] i_mode,
    input wire       o_ready,
    input wire       o_done,
    input wire       o_timeout,
    input wire       o_wide,
    input wire       o_cs0_n,
    input wire       o_cs1_n,
    input wire [2:0] o_da,
    input wire       o_iord_n,
    input wire       o_iowr_n,
    input wire       o_dd_oe_n
);
    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    reg  [7:0] cnt;
    reg  [7:0] rec;
    reg  [2:0] cm;
    reg  [2:0] pm;
    reg        cb;
    wire       stb = !o_iord_n || !o_iowr_n;
    // strobe and recovery floors in 20 ns clocks, rounded up
    wire [7:0] t2n = (cb && cm < 3'h3) ? 8'h0f : (cm == 3'h0) ? 8'h09 :
                     (cm == 3'h1) ? 8'h07 : (cm == 3'h2) ? 8'h05 :
                     (cm > 3'h5) ? 8'h03 : 8'h04;
    // recovery belongs to the mode of the cycle before the current one
    wire [7:0] t2i = (pm == 3'h3) ? 8'h04 : (pm > 3'h5) ? 8'h01 :
                     (pm > 3'h3) ? 8'h02 : 8'h00;

    always @(posedge i_clock or negedge i_rstn)
        if (!i_rstn)
            {cnt, rec, cm, pm, cb} <= {8'h00, 8'hff, 3'h0, 3'h0, 1'b0};
        else
        begin
            cnt <= stb ? cnt + 8'h01 : 8'h00;
            rec <= stb ? 8'h00 : rec + {7'h00, rec != 8'hff};
            if (o_ready && i_req)
                {pm, cm, cb} <= {cm, i_mode, i_byte};
        end

    default clocking mon_clk @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    AST_IDLE_QUIET: assert property (o_ready |-> o_cs0_n && o_cs1_n
        && !stb && o_dd_oe_n) else $error("bus active while idle");
    AST_TAKE_SELECT: assert property (o_ready && i_req |=> !o_ready
        && o_da == $past(i_addr) && o_cs1_n == !$past(i_cs1)
        && o_cs0_n == $past(i_cs1)) else $error("select not from request");
    AST_DATA_DRIVE: assert property (stb |-> o_dd_oe_n == o_iowr_n)
        else $error("data drive does not follow direction");
    AST_STROBE_MIN: assert property ($fell(stb) |-> cnt >= t2n)
        else $error("strobe shorter than its minimum");
    AST_FAST_NO_WAIT: assert property (stb && cm > 3'h4 |-> cnt < 8'h07)
        else $error("cycle stretched in a mode without wait");
    AST_WAIT_BOUND: assert property (stb |-> cnt < 8'h5a)
        else $error("strobe held past the ready limit");
    AST_RECOVERY: assert property ($rose(stb) |-> rec >= t2i)
        else $error("strobe recovery too short");
    AST_DONE_AT_END: assert property (o_done |-> !stb && $past(stb))
        else $error("done not at strobe negation");
    AST_WIDE_FAST: assert property (o_done && cm > 3'h2 |-> o_wide == !cb)
        else $error("width indication used in a fast mode");
    AST_TIMEOUT_PULSE: assert property (o_timeout |-> o_done ##1 !o_done)
        else $error("timeout not a single pulse with done");
endmodule // pio_host_monitor

bind pio_host pio_host_monitor u_pio_host_monitor (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_req(i_req), .i_cs1(i_cs1),
    .i_addr(i_addr), .i_byte(i_byte), .i_mode(i_mode), .o_ready(o_ready),
    .o_done(o_done), .o_timeout(o_timeout), .o_wide(o_wide),
    .o_cs0_n(o_cs0_n), .o_cs1_n(o_cs1_n), .o_da(o_da),
    .o_iord_n(o_iord_n), .o_iowr_n(o_iowr_n), .o_dd_oe_n(o_dd_oe_n));

// ===== sim/pio_dev_model.sv
// behavioural model of the register device behind the pio pins
`timescale 1ns/1ps
module pio_dev_model (
    input  wire        i_clock,
    input  wire        i_rstn,
    input  wire        i_cs0_n,
    input  wire        i_cs1_n,
    input  wire [2:0]  i_da,
    input  wire        i_iord_n,
    input  wire        i_iowr_n,
    input  wire [15:0] i_dd,
    input  wire [7:0]  i_wait,
    input  wire        i_wide_en,
    output wire [15:0] o_dd,
    output wire        o_iordy,
    output wire        o_iocs16_n
);
    // ------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------
    reg  [15:0] mem [0:15];
    reg  [15:0] last;
    reg  [7:0]  wcnt;
    wire        sel = !i_cs0_n || !i_cs1_n;
    wire [3:0]  idx = {!i_cs1_n, i_da};
    wire        stb = sel && (!i_iord_n || !i_iowr_n);
    wire        drv = sel && !i_iord_n;

    // ready drops at the strobe edge and returns to the pull-up level as
    // soon as the wait runs out; waits over the limit only when commanded
    assign o_iordy = !(stb && wcnt < i_wait);
    assign o_iocs16_n = !(sel && i_wide_en);
    // data valid from the strobe edge, so never behind ready; a bus nobody
    // drives shows the inverse of the last value instead of holding it
    assign o_dd = drv ? mem[idx] : ~last;

    always @(posedge i_clock or negedge i_rstn)
        if (!i_rstn)
            {wcnt, last} <= {8'h00, 16'h0000};
        else
        begin
            wcnt <= stb ? wcnt + 8'h01 : 8'h00;
            if (drv)
                last <= mem[idx];
            if (sel && !i_iowr_n)
                mem[idx] <= i_dd;
        end
endmodule // pio_dev_model

// ===== sim/pio_host_tb.sv
// self-checking testbench for the pio host cycle controller
`timescale 1ns/1ps
module pio_host_tb;
    typedef struct {logic [15:0] rd; logic wide, tmo, chk;} pio_exp_t;
    logic        clk, rstn, req, wr, cs1, byt, wide_en;
    logic [2:0]  addr, mode;
    logic [7:0]  wait_cyc;
    logic [15:0] wdata;
    logic [15:0] sh [0:15];
    wire         ready, done, tmo, wide, cs0_n, cs1_n, iord_n, iowr_n;
    wire         oe_n, iordy, iocs16_n;
    wire  [2:0]  da;
    wire  [15:0] rdata, h_dd, dev_dd;
    wire  [15:0] dd_bus = !oe_n ? h_dd : dev_dd;
    int          n_mismatch = 0;
    int          total_checks = 0;
    pio_exp_t    q[$];

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    pio_host u_pio_host (
        .i_clock(clk), .i_rstn(rstn), .i_req(req), .i_write(wr),
        .i_cs1(cs1), .i_addr(addr), .i_byte(byt), .i_wdata(wdata),
        .i_mode(mode), .o_ready(ready), .o_done(done), .o_timeout(tmo),
        .o_wide(wide), .o_rdata(rdata), .o_cs0_n(cs0_n), .o_cs1_n(cs1_n),
        .o_da(da), .o_iord_n(iord_n), .o_iowr_n(iowr_n), .i_dd(dd_bus),
        .o_dd(h_dd), .o_dd_oe_n(oe_n), .i_iordy(iordy),
        .i_iocs16_n(iocs16_n));
    pio_dev_model u_pio_dev_model (
        .i_clock(clk), .i_rstn(rstn), .i_cs0_n(cs0_n), .i_cs1_n(cs1_n),
        .i_da(da), .i_iord_n(iord_n), .i_iowr_n(iowr_n), .i_dd(dd_bus),
        .i_wait(wait_cyc), .i_wide_en(wide_en), .o_dd(dev_dd),
        .o_iordy(iordy), .o_iocs16_n(iocs16_n));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        n_mismatch += int'(got !== exp);
        if (got !== exp)
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one access launched at a falling edge; returns its length in clocks
    task automatic access(input logic w, input logic [3:0] ix,
        input logic b, input logic [15:0] d, input logic [2:0] m,
        output int lat);
        pio_exp_t e;
        e.wide = !b && (m > 3'h2 || wide_en);
        e.tmo  = m < 3'h5 && wait_cyc > 8'h40;
        e.chk  = !w && !e.tmo;
        e.rd   = e.wide ? sh[ix] : {8'h00, sh[ix][7:0]};
        for (lat = 0; ready !== 1'b1 && lat < 300; lat++) @(negedge clk);
        q.push_back(e);
        {req, wr, cs1, addr, byt, wdata, mode} = {1'b1, w, ix, b, d, m};
        @(negedge clk);
        req = 1'b0;
        for (lat = 1; done !== 1'b1 && lat < 300; lat++) @(negedge clk);
        if (w)
            sh[ix] = b ? {8'h00, d[7:0]} : d;
    endtask

    // results are matched in completion order against the notes queue
    initial
    begin
        pio_exp_t e;
        forever
        begin
            @(negedge clk);
            if (done === 1'b1)
            begin
                e = q.size() > 0 ? q.pop_front()
                                 : '{16'hxxxx, 1'bx, 1'bx, 1'b1};
                if (e.chk)
                    check(rdata, e.rd);
                check({14'h0, wide, tmo}, {14'h0, e.wide, e.tmo});
            end
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        int          l0, l1, l2;
        logic [3:0]  ix;
        logic [15:0] d;
        {rstn, req, wr, cs1, addr, byt, wdata, mode} = 27'h0000000;
        {wait_cyc, wide_en} = 9'h001;
        void'($urandom(32'h9c24a37e));
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        check({9'h000, cs0_n, cs1_n, iord_n, iowr_n, oe_n, ready, done},
              16'h007e);
        $display("test reset done");
        for (int m = 0; m < 7; m++)
        begin
            ix = 4'($urandom);
            d  = 16'($urandom);
            access(1'b1, ix, 1'b0, d, 3'(m), l0);
            access(1'b0, ix, 1'b0, d, 3'(m), l0);
            access(1'b1, ix, 1'b1, ~d, 3'(m), l0);
            access(1'b0, ix, 1'b1, d, 3'(m), l0);
        end
        $display("test modes done");
        access(1'b1, 4'h5, 1'b0, 16'ha5c3, 3'h4, l0);
        wide_en = 1'b0;
        access(1'b0, 4'h5, 1'b0, 16'h0000, 3'h1, l0);
        access(1'b0, 4'h5, 1'b0, 16'h0000, 3'h4, l0);
        wide_en = 1'b1;
        $display("test width done");
        access(1'b0, 4'h5, 1'b0, 16'h0000, 3'h4, l0);
        wait_cyc = 8'h01;
        access(1'b0, 4'h5, 1'b0, 16'h0000, 3'h4, l1);
        check(16'(l1), 16'(l0));
        wait_cyc = 8'h14;
        access(1'b0, 4'h5, 1'b0, 16'h0000, 3'h4, l2);
        check({15'h0000, l2 > l0 + 10}, 16'h0001);
        access(1'b1, 4'h9, 1'b0, 16'h3cc3, 3'h3, l1);
        access(1'b0, 4'h9, 1'b0, 16'h0000, 3'h3, l1);
        wait_cyc = 8'h04;
        access(1'b0, 4'h5, 1'b0, 16'h0000, 3'h0, l1);
        access(1'b0, 4'h5, 1'b0, 16'h0000, 3'h5, l1);
        wait_cyc = 8'h00;
        access(1'b0, 4'h5, 1'b0, 16'h0000, 3'h5, l0);
        check(16'(l1), 16'(l0));
        $display("test wait done");
        // a device stuck past the ready limit, commanded on purpose
        wait_cyc = 8'hc8;
        access(1'b0, 4'h5, 1'b0, 16'h0000, 3'h0, l0);
        wait_cyc = 8'h00;
        access(1'b0, 4'h5, 1'b0, 16'h0000, 3'h0, l0);
        $display("test timeout done");
        repeat (2) @(negedge clk);
        check(16'(q.size()), 16'h0000);
        report_and_stop();
    end
endmodule // pio_host_tb
